//--- core/flr_log_core.v
// flr_log_core.v: builds the fault log record and serves it as a byte image
// assumes measurement and status inputs are already on clk_sys; the nvm
// writer consumes wr_valid/wr_addr/wr_data with wr_ready back-pressure
// a record is written once; later faults are ignored until the log is erased or rstn resets the core
`timescale 1ns/1ps
`include "flr_consts.vh"
// Contract
// (R01) previous event at bytes 47 to 66
// (R02) event fields in documented twenty-byte order
// (R03) oldest event at bytes 127 to 146
// (R04) sixteen-bit fields stored high byte first
// (R05) manual capture gives code all-ones
// (R06) channel 0 fault codes as listed
// (R07) channel 1 codes are channel 0 plus 0x10
// (R08) erase command wipes stored log
// (R09) erase clears log-present status bit 3
// (R10) status cleared within 8 ms of erase
// (R11) host sends erase as send-byte, no data
// (R12) header: code byte 0, timer bytes 1-6 LSB first
// (R13) current event at 27, finish cycle then write
// (R14) no unlisted fault-source codes emitted
module flr_log_core #(
  parameter ERASE_CYC = `FLR_ERASE_CYC,
  parameter TICK_CYC  = `FLR_TICK_CYC
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        ce,
  input  wire [7:0]  fault_ch0,
  input  wire [7:0]  fault_ch1,
  input  wire        manual_log_capture,
  input  wire        log_erase_command,
  input  wire        cycle_done,
  input  wire [15:0] vout0,
  input  wire [15:0] vout1,
  input  wire [15:0] iout0,
  input  wire [15:0] iout1,
  input  wire [15:0] vin,
  input  wire [15:0] iin,
  input  wire [7:0]  stat_vout0,
  input  wire [7:0]  stat_vout1,
  input  wire [15:0] stat_word0,
  input  wire [15:0] stat_word1,
  input  wire [7:0]  vendor_stat0,
  input  wire [7:0]  vendor_stat1,
  input  wire [7:0]  hdr_peak_byte,
  input  wire        wr_ready,
  output reg         wr_valid,
  output reg  [7:0]  wr_addr,
  output reg  [7:0]  wr_data,
  output reg         wr_erase,
  output reg         log_present,
  output reg         busy
);
  localparam EVT_BITS = `FLR_EVT_BYTES * 8;
  localparam NBYTE = `FLR_EVT_BYTES * `FLR_EVT_COUNT;
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_WRITE = 2'd2;
  localparam ST_ERASE = 2'd3;

  reg [1:0]       state_r;
  reg [7:0]       code_r;
  reg [47:0]      time_since_reset_counter_r;
  reg [47:0]      snap_time_r;
  reg [15:0]      tick_r;
  reg [22:0]      erase_cnt_r;
  reg [7:0]       addr_r;
  reg [NBYTE*8-1:0] ring_r;
  reg             pending_r;
  wire [7:0]      enc_code;
  wire            enc_valid;
  wire [159:0]    evt_now;
  reg  [7:0]      byte_nxt;
  integer         k;
  wire [NBYTE*8+EVT_BITS-1:0] hist_chain;
  wire [NBYTE*8-1:0]          ring_nxt;
  wire                        hist_shift;
  genvar                      g;

  flr_code_enc u_enc (
    .fault_ch0 (fault_ch0),
    .fault_ch1 (fault_ch1),
    .manual    (manual_log_capture),
    .code      (enc_code),
    .valid     (enc_valid)
  );

  // event image, byte 0 of record in the top bits, words high byte first
  assign evt_now = {vout0, vout1, iout0, iout1, vin, iin, // R02 R04
                    stat_vout0, stat_vout1, stat_word0, stat_word1,
                    vendor_stat0, vendor_stat1};

  // history chain: the live cycle feeds the newest slot and every slot but the
  // oldest hands its event one place older; frozen while a record streams out
  assign hist_chain = {evt_now, ring_r};
  assign hist_shift = cycle_done && (state_r != ST_WRITE);

  // one slot of the six-event history per pass, newest at the top
  generate
    for (g = 0; g < `FLR_EVT_COUNT; g = g + 1) begin : g_slot
      assign ring_nxt[NBYTE*8-1-g*EVT_BITS -: EVT_BITS] =
        hist_chain[NBYTE*8+EVT_BITS-1-g*EVT_BITS -: EVT_BITS];
    end
  endgenerate

  // free-running time since reset, 200 us steps
  // 48 bits outlast the part, so the counter carries no overflow handling
  always @(posedge clk_sys) begin
    if (!rstn) begin
      tick_r <= 16'h0000;
      time_since_reset_counter_r <= 48'h0000_0000_0000;
    end else if (ce) begin
      if (tick_r == TICK_CYC[15:0] - 16'h0001) begin
        tick_r <= 16'h0000;
        time_since_reset_counter_r <= time_since_reset_counter_r + 48'h0000_0000_0001; // R12
      end else begin
        tick_r <= tick_r + 16'h0001;
      end
    end
  end

  // record byte selection by address; past the last byte nothing is read
  always @* begin
    byte_nxt = 8'h00;
    k        = 0;
    if (addr_r == `FLR_HDR_CODE_POS) begin
      byte_nxt = code_r; // R12
    end else if (addr_r < `FLR_HDR_TIME_POS + 6) begin
      // timer snapshot goes out least significant byte first
      byte_nxt = snap_time_r[(addr_r - `FLR_HDR_TIME_POS)*8 +: 8]; // R12
    end else if (addr_r < `FLR_EVT_CUR_POS) begin
      byte_nxt = hdr_peak_byte;
    end else if (addr_r < `FLR_LOG_BYTES) begin
      // current at 27, previous at 47, oldest at 127..146
      k = addr_r - `FLR_EVT_CUR_POS; // R01 R03 R13
      byte_nxt = ring_r[NBYTE*8-1-k*8 -: 8];
    end
  end

  // capture, sequencing and erase
  // wr_erase is a one-cycle strobe; every other output is a held level
  always @(posedge clk_sys) begin
    if (!rstn) begin
      state_r     <= ST_IDLE;
      code_r      <= 8'h00;
      snap_time_r <= 48'h0000_0000_0000;
      ring_r      <= {NBYTE*8{1'b0}};
      addr_r      <= 8'h00;
      erase_cnt_r <= 23'h00_0000;
      pending_r   <= 1'b0;
      wr_valid    <= 1'b0;
      wr_addr     <= 8'h00;
      wr_data     <= 8'h00;
      wr_erase    <= 1'b0;
      log_present <= 1'b0;
      busy        <= 1'b0;
    end else if (ce) begin
      wr_erase <= 1'b0;
      // age the six-event history; held during the write so the image
      // cannot change under the byte stream
      if (hist_shift) begin
        ring_r <= ring_nxt;
      end
      case (state_r)
        ST_IDLE: begin
          // erase first, so a host clear beats a capture in the same cycle; one sent outside idle is dropped
          if (log_erase_command) begin
            state_r     <= ST_ERASE;
            erase_cnt_r <= 23'h00_0000;
            wr_erase    <= 1'b1; // R08
            busy        <= 1'b1;
          end else if (enc_valid && !log_present) begin
            code_r      <= enc_code; // R05 R06 R07 R14
            snap_time_r <= time_since_reset_counter_r;
            state_r     <= ST_WAIT;
            busy        <= 1'b1;
          end
        end
        ST_WAIT: begin
          // the cycle in which the fault struck must finish first, so the
          // current event holds a complete set of readings
          if (cycle_done) begin
            state_r <= ST_WRITE; // R13
            addr_r  <= 8'h00;
          end
        end
        ST_WRITE: begin
          // one byte per accepted beat; a beat holds until the writer takes
          // it, and pending_r marks that the last byte is on the port, so
          // the record closes only once byte 146 has been accepted
          if (!wr_valid || wr_ready) begin
            if (pending_r && wr_valid && wr_addr == `FLR_LOG_BYTES - 1) begin
              wr_valid    <= 1'b0;
              pending_r   <= 1'b0;
              state_r     <= ST_IDLE;
              log_present <= 1'b1;
              busy        <= 1'b0;
            end else if (!pending_r) begin
              wr_valid  <= 1'b1;
              wr_addr   <= addr_r;
              wr_data   <= byte_nxt;
              addr_r    <= addr_r + 8'h01;
              pending_r <= (addr_r == `FLR_LOG_BYTES - 1);
            end
          end
        end
        ST_ERASE: begin
          // the present flag drops at once; busy covers the whole erase
          // time so a new capture cannot race the wipe
          log_present <= 1'b0; // R09
          if (erase_cnt_r == ERASE_CYC[22:0] - 23'h00_0001) begin
            state_r <= ST_IDLE; // R10
            busy    <= 1'b0;
          end else begin
            erase_cnt_r <= erase_cnt_r + 23'h00_0001;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // flr_log_core

//--- core/flr_consts.vh
// flr_consts.vh: offsets, codes and timing for the fault log record builder
// assumes inclusion by bare name from the core design files
`ifndef FLR_CONSTS_VH
`define FLR_CONSTS_VH
// record layout
`define FLR_LOG_BYTES       147
`define FLR_HDR_CODE_POS    0
`define FLR_HDR_TIME_POS    1
`define FLR_EVT_CUR_POS     27
`define FLR_EVT_PREV_POS    47
`define FLR_EVT_OLD_POS     127
`define FLR_EVT_BYTES       20
`define FLR_EVT_COUNT       6
// fault-source codes
`define FLR_CODE_MANUAL     8'hFF
`define FLR_CODE_TON        8'h00
`define FLR_CODE_VOUT_OV    8'h01
`define FLR_CODE_VOUT_UV    8'h02
`define FLR_CODE_IOUT_OC    8'h03
`define FLR_CODE_OT         8'h05
`define FLR_CODE_UT         8'h06
`define FLR_CODE_VIN_OV     8'h07
`define FLR_CODE_DIE_OT     8'h0A
`define FLR_CODE_CH1_OFS    8'h10
// vendor status bit for log present
`define FLR_LOG_PRESENT_BIT 3
// timing
`define FLR_CLK_HZ          10000000
`define FLR_TICK_US         200
`define FLR_TICK_CYC        ((`FLR_CLK_HZ / 1000000) * `FLR_TICK_US)
`define FLR_ERASE_MS        8
`define FLR_ERASE_CYC       ((`FLR_CLK_HZ / 1000) * `FLR_ERASE_MS)
`endif

//--- core/flr_code_enc.v
// flr_code_enc.v: maps a one-hot fault vector to the fault-source code
// assumes fault inputs are from the same clock domain
`timescale 1ns/1ps
`include "flr_consts.vh"
module flr_code_enc (
  input  wire [7:0] fault_ch0,
  input  wire [7:0] fault_ch1,
  input  wire       manual,
  output reg  [7:0] code,
  output reg        valid
);
  reg [7:0] base;
  reg [7:0] vec;
  reg       hit;
  // lowest set bit wins; order ton, ov, uv, oc, ot, ut, vin_ov, die_ot
  always @* begin
    base  = `FLR_CODE_TON;
    vec   = (|fault_ch0) ? fault_ch0 : fault_ch1;
    hit   = |vec;
    if (vec[0]) base = `FLR_CODE_TON; // R06
    else if (vec[1]) base = `FLR_CODE_VOUT_OV;
    else if (vec[2]) base = `FLR_CODE_VOUT_UV;
    else if (vec[3]) base = `FLR_CODE_IOUT_OC;
    else if (vec[4]) base = `FLR_CODE_OT;
    else if (vec[5]) base = `FLR_CODE_UT;
    else if (vec[6]) base = `FLR_CODE_VIN_OV;
    else if (vec[7]) base = `FLR_CODE_DIE_OT;
    code  = base;
    valid = hit | manual;
    if (manual) code = `FLR_CODE_MANUAL; // R05
    else if (~(|fault_ch0) && hit) code = base + `FLR_CODE_CH1_OFS; // R07
  end
endmodule // flr_code_enc

//--- verification/flr_log_props.sv
// flr_log_props.sv: assertions on the log writer and erase outputs
// assumes it is bound to flr_log_core with ERASE_CYC set to 20
`timescale 1ns/1ps
module flr_log_props (
  input wire       clk_sys,
  input wire       rstn,
  input wire       wr_ready,
  input wire       wr_valid,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire       wr_erase,
  input wire       log_present,
  input wire       busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // an accepted beat, and the beat that carries the last byte
  sequence s_beat; wr_valid && wr_ready; endsequence
  sequence s_last; s_beat ##0 wr_addr == 8'h92; endsequence
  a_code_listed: assert property (wr_valid && wr_addr == 8'h00 |-> wr_data inside
    {8'hFF, [8'h00:8'h03], [8'h05:8'h07], 8'h0A, [8'h10:8'h13], [8'h15:8'h17], 8'h1A})
    else $error("unlisted fault code");
  a_first_addr: assert property ($rose(wr_valid) |-> wr_addr == 8'h00)
    else $error("record does not start at byte 0");
  a_beat_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("beat changed while stalled");
  a_addr_step: assert property (s_beat ##0 wr_addr != 8'h92 |=> !wr_valid || wr_addr == $past(wr_addr) + 8'h01)
    else $error("byte address skipped");
  a_last_done: assert property (s_last |-> ##[1:2] (log_present && !busy))
    else $error("log not closed after byte 146");
  a_erase_pulse: assert property (wr_erase |-> !wr_valid ##1 !wr_erase)
    else $error("erase pulse malformed");
  a_erase_flag: assert property (wr_erase |=> !log_present)
    else $error("log present not cleared");
  a_erase_busy: assert property (wr_erase |-> busy[*8] ##[1:40] !busy)
    else $error("erase busy span wrong");
endmodule // flr_log_props
bind flr_log_core flr_log_props i_props (.clk_sys(clk_sys), .rstn(rstn), .wr_ready(wr_ready),
  .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_erase(wr_erase),
  .log_present(log_present), .busy(busy));

//--- verification/flr_nvm_model.sv
// flr_nvm_model.sv: behavioural nonvolatile store behind the log writer
// assumes one clock; stall makes it raise wr_ready only every other cycle
`timescale 1ns/1ps
module flr_nvm_model (
  input  wire       clk_sys,
  input  wire       stall,
  input  wire       wr_valid,
  input  wire [7:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire       wr_erase,
  output logic      wr_ready
);
  logic [7:0] mem [0:146];
  initial wr_ready = 1'b0;
  // store accepted bytes; erase leaves the blank value everywhere
  always @(posedge clk_sys) begin
    if (wr_erase) begin
      foreach (mem[i]) mem[i] <= 8'hFF;
    end else if (wr_valid && wr_ready) begin
      mem[wr_addr] <= wr_data;
    end
    wr_ready <= !stall || !wr_ready;
  end
endmodule // flr_nvm_model

//--- verification/tb_flr_log_core.sv
// tb_flr_log_core.sv: self-checking bench for the fault log record builder
// assumes the nvm model answers the write port; event k gives byte values from k
`timescale 1ns/1ps
module tb_flr_log_core;
  logic clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, man = 1'b0, ers = 1'b0, cdn = 1'b0, stall = 1'b0;
  logic [7:0] f0 = 8'h00, f1 = 8'h00, k = 8'h00;
  wire        wr_ready, wr_valid, wr_erase, log_present, busy;
  wire  [7:0] wr_addr, wr_data;
  logic [24:0] row [0:16];
  int fails = 0, tests_run = 0;
  time t_rel = 0;
  localparam int TICK_NS = 500; // five 100 ns cycles per timer step
  localparam logic [63:0] CD = 64'h0A07_0605_0302_0100;
  always #50 clk_sys = ~clk_sys;
  flr_log_core #(.ERASE_CYC(20), .TICK_CYC(5)) i_dut (.clk_sys(clk_sys), .rstn(rstn),
    .ce(ce), .fault_ch0(f0), .fault_ch1(f1), .manual_log_capture(man),
    .log_erase_command(ers), .cycle_done(cdn), .vout0({k, 8'h01}), .vout1({k, 8'h03}),
    .iout0({k, 8'h05}), .iout1({k, 8'h07}), .vin({k, 8'h09}), .iin({k, 8'h0B}),
    .stat_vout0({k[3:0], 4'hC}), .stat_vout1({k[3:0], 4'hD}), .stat_word0({k, 8'h0F}),
    .stat_word1({k, 8'h11}), .vendor_stat0({k[3:0], 4'h2}), .vendor_stat1({k[3:0], 4'h3}),
    .hdr_peak_byte(8'h5A), .wr_ready(wr_ready), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_erase(wr_erase), .log_present(log_present), .busy(busy));
  flr_nvm_model i_nvm (.clk_sys(clk_sys), .stall(stall), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_erase(wr_erase), .wr_ready(wr_ready));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic results();
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // expected byte b of event k: words high byte first, low byte equals b
  function automatic logic [7:0] ev(input logic [7:0] kk, input logic [4:0] b);
    if (b == 5'd12 || b == 5'd13 || b >= 5'd18) return {kk[3:0], b[3:0]};
    else if (b[0]) return {3'b000, b};
    else return kk;
  endfunction
  // five plain cycles, then the fault with event 6, then the write
  task automatic cap(input logic [24:0] r);
    logic [47:0] tc;
    tc = 48'h0000_0000_0000;
    for (int i = 1; i <= 6; i++) begin
      k = 8'(i);
      if (i == 6) begin
        {f0, f1, man} = r[24:8];
        tc = 48'(($time - t_rel) / TICK_NS); // timer value at the capture edge
      end
      @(negedge clk_sys);
      cdn = 1'b1;
      @(negedge clk_sys);
      cdn = 1'b0;
    end
    repeat (2000) if (!log_present) @(negedge clk_sys);
    {f0, f1, man} = 17'h0_0000;
    chk({7'h00, log_present}, 8'h01);
    chk(i_nvm.mem[0], r[7:0]);
    for (int j = 0; j < 6; j++) chk(i_nvm.mem[1 + j], tc[8*j +: 8]);
    chk(i_nvm.mem[26], 8'h5A);
    for (int b = 0; b < 20; b++) begin
      chk(i_nvm.mem[27 + b], ev(8'h06, 5'(b)));
      chk(i_nvm.mem[47 + b], ev(8'h05, 5'(b)));
      chk(i_nvm.mem[127 + b], ev(8'h01, 5'(b)));
    end
  endtask
  // erase the log and watch the status and the store
  task automatic erase();
    ers = 1'b1;
    @(negedge clk_sys);
    ers = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({7'h00, log_present}, 8'h00);
    repeat (60) if (busy) @(negedge clk_sys);
    chk({7'h00, busy}, 8'h00);
    chk(i_nvm.mem[0], 8'hFF);
    chk(i_nvm.mem[146], 8'hFF);
  endtask
  // rows: channel 0 faults, channel 1 faults, manual capture
  initial begin
    for (int i = 0; i < 8; i++) begin
      row[i] = {8'h01 << i, 8'h00, 1'b0, CD[8*i +: 8]};
      row[i + 8] = {8'h00, 8'h01 << i, 1'b0, CD[8*i +: 8] | 8'h10};
    end
    row[16] = {16'h0000, 1'b1, 8'hFF};
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    t_rel = $time;
    foreach (row[r]) begin
      stall = r[0];
      cap(row[r]);
      erase();
    end
    // reset in the middle of a record write
    f0 = 8'h02;
    repeat (2) @(negedge clk_sys);
    cdn = 1'b1;
    @(negedge clk_sys);
    cdn = 1'b0;
    repeat (9) @(negedge clk_sys);
    rstn = 1'b0;
    @(negedge clk_sys);
    chk({4'h0, wr_valid, wr_erase, log_present, busy}, 8'h00);
    rstn = 1'b1;
    t_rel = $time;
    f0 = 8'h00;
    // first edges after release stay idle, then a full record again
    repeat (2) @(negedge clk_sys);
    chk({4'h0, wr_valid, wr_erase, log_present, busy}, 8'h00);
    cap(row[3]);
    erase();
    results();
  end
  // watchdog well beyond the expected run length
  initial begin
    #2_000_000;
    fails++;
    results();
  end
endmodule // tb_flr_log_core
